// *** verilog/ptm_timer.sv ***
// Periodic timer: 10-bit up counter, comparators A and P, output pin and capture.
// Assumes an Avalon-MM master on clk_in and pin inputs synchronous to clk_in.
`timescale 1ns/10ps
`include "ptm_map.svh"

// Operation
// - 10-bit counter, comparators A and P.
// - counter_on rising edge zeroes counter.
// - counter clears on overflow or match.
// - pause_ctrl holds counter, resumes later.
// - count_clk_sel picks counting clock source.
// - counter_on low stops, keeps value.
// - counter_on rise restores initial pin level.
// - op_mode_sel picks one of four modes.
// - compare mode: match A acts on pin.
// - PWM mode: pin_func_sel picks output.
// - capture mode: pin_func_sel picks edge.
// - requested level equals initial: no change.
// - out_level_ctrl: initial or active level.
// - out_invert inverts pin in every mode.
// - capture_src_sel picks capture trigger pin.
// - clear_sel picks A or P clearing.
// - clear_sel ignored in PWM, capture.
// - counter readable as low/high bytes.
// - flags A and P per clear_sel.
module ptm_timer
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output logic [1:0] avs_response_out,
	input wire logic fsub_tick_in,
	input wire logic fh_tick_in,
	input wire logic ext_clk_pin_in,
	input wire logic capture_in_pin_in,
	output logic timer_out_pin_out,
	output logic timer_out_pin_oe_out,
	output logic match_a_flag_out,
	output logic match_p_flag_out
);
	import ptm_pkg::*;

	// ======================================================================
	// Reset release
	logic rst_meta_reg;
	logic rst_n_reg;
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// ======================================================================
	// Registers and bus slave
	logic [7:0] ctrl0_reg;
	logic [7:0] ctrl1_reg;
	logic [9:0] cmp_a_value_reg;
	logic [9:0] cmp_p_value_reg;
	logic [9:0] count_reg;
	logic [9:0] capture_reg;
	logic flag_a_reg;
	logic flag_p_reg;
	logic flag_cap_reg;
	logic rd_done_reg;
	logic [31:0] rdata_reg;

	logic counter_on;
	logic pause_ctrl;
	ptm_clk_t count_clk_sel;
	ptm_mode_t op_mode_sel;
	ptm_io_t pin_func_sel;
	logic out_level_ctrl;
	logic out_invert;
	logic capture_src_sel;
	logic clear_sel;
	assign counter_on = ctrl0_reg[`PTM_C0_ON];
	assign pause_ctrl = ctrl0_reg[`PTM_C0_PAUSE];
	assign count_clk_sel = ptm_clk_t'(ctrl0_reg[`PTM_C0_CLK_HI:`PTM_C0_CLK_LO]);
	assign op_mode_sel = ptm_mode_t'(ctrl1_reg[`PTM_C1_MODE_HI:`PTM_C1_MODE_LO]);
	assign pin_func_sel = ptm_io_t'(ctrl1_reg[`PTM_C1_IO_HI:`PTM_C1_IO_LO]);
	assign out_level_ctrl = ctrl1_reg[`PTM_C1_OC];
	assign out_invert = ctrl1_reg[`PTM_C1_POL];
	assign capture_src_sel = ctrl1_reg[`PTM_C1_CAPS];
	assign clear_sel = ctrl1_reg[`PTM_C1_CCLR];

	logic wr_lo;
	assign wr_lo = avs_write_in && avs_byteenable_in[0];

	// Writes finish in the cycle they arrive; reads wait one cycle for registered data.
	assign avs_waitrequest_out = avs_read_in && !rd_done_reg;
	assign avs_readdata_out = rdata_reg;
	assign avs_response_out = 2'b00;

	function automatic logic [31:0] ptm_byte(input logic [7:0] b);
		ptm_byte = {24'h00_0000, b};
	endfunction : ptm_byte

	always_ff @(posedge clk_in or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			ctrl0_reg <= `PTM_RST_BYTE;
			ctrl1_reg <= `PTM_RST_BYTE;
			cmp_a_value_reg <= `PTM_RST_CNT;
			cmp_p_value_reg <= `PTM_RST_CNT;
		end
		else if (wr_lo)
		begin
			case (avs_address_in)
				`PTM_OFS_CTRL0: ctrl0_reg <= avs_writedata_in[7:0] & `PTM_C0_MASK;
				`PTM_OFS_CTRL1: ctrl1_reg <= avs_writedata_in[7:0];
				`PTM_OFS_CMPA_LO: cmp_a_value_reg[7:0] <= avs_writedata_in[7:0];
				`PTM_OFS_CMPA_HI: cmp_a_value_reg[9:8] <= avs_writedata_in[1:0];
				`PTM_OFS_PER_LO: cmp_p_value_reg[7:0] <= avs_writedata_in[7:0];
				`PTM_OFS_PER_HI: cmp_p_value_reg[9:8] <= avs_writedata_in[1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			rd_done_reg <= 1'b0;
			rdata_reg <= `PTM_BAD_READ;
		end
		else
		begin
			rd_done_reg <= avs_read_in && !rd_done_reg;
			if (avs_read_in && !rd_done_reg)
			begin
				case (avs_address_in)
					`PTM_OFS_CTRL0: rdata_reg <= ptm_byte(ctrl0_reg);
					`PTM_OFS_CTRL1: rdata_reg <= ptm_byte(ctrl1_reg);
					`PTM_OFS_CNT_LO: rdata_reg <= ptm_byte(count_reg[7:0]);
					`PTM_OFS_CNT_HI: rdata_reg <= ptm_byte({6'h00, count_reg[9:8]});
					`PTM_OFS_CMPA_LO: rdata_reg <= ptm_byte(cmp_a_value_reg[7:0]);
					`PTM_OFS_CMPA_HI: rdata_reg <= ptm_byte({6'h00, cmp_a_value_reg[9:8]});
					`PTM_OFS_PER_LO: rdata_reg <= ptm_byte(cmp_p_value_reg[7:0]);
					`PTM_OFS_PER_HI: rdata_reg <= ptm_byte({6'h00, cmp_p_value_reg[9:8]});
					`PTM_OFS_FLAGS: rdata_reg <= {capture_reg, 19'h0_0000,
						flag_cap_reg, flag_p_reg, flag_a_reg};
					default: rdata_reg <= `PTM_BAD_READ;
				endcase
			end
		end
	end

	// ======================================================================
	// Counting clock selection
	logic [5:0] div_reg;
	logic ext_clk_d_reg;
	logic cap_in_d_reg;
	logic on_d_reg;
	always_ff @(posedge clk_in or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			div_reg <= 6'h00;
			ext_clk_d_reg <= 1'b0;
			cap_in_d_reg <= 1'b0;
			on_d_reg <= 1'b0;
		end
		else
		begin
			div_reg <= div_reg + 6'h01;
			ext_clk_d_reg <= ext_clk_pin_in;
			cap_in_d_reg <= capture_in_pin_in;
			on_d_reg <= counter_on;
		end
	end

	logic ext_rise;
	logic ext_fall;
	logic on_rise;
	logic div_tick;
	// Internal rates divide down in one shared counter, so each tick is one clk_in cycle.
	function automatic logic ptm_div_hit(input logic [5:0] cnt, input logic [5:0] last);
		ptm_div_hit = ((cnt & last) == last);
	endfunction : ptm_div_hit
	assign ext_rise = ext_clk_pin_in && !ext_clk_d_reg;
	assign ext_fall = !ext_clk_pin_in && ext_clk_d_reg;
	assign on_rise = counter_on && !on_d_reg;

	always_comb
	begin
		case (count_clk_sel)
			PTM_CK_SYS4: div_tick = ptm_div_hit(div_reg, `PTM_DIV4_LAST);
			PTM_CK_SYS: div_tick = 1'b1;
			PTM_CK_H16: div_tick = fh_tick_in && ptm_div_hit(div_reg, `PTM_DIV16_LAST);
			PTM_CK_H64: div_tick = fh_tick_in && ptm_div_hit(div_reg, `PTM_DIV64_LAST);
			PTM_CK_SUB0, PTM_CK_SUB1: div_tick = fsub_tick_in;
			PTM_CK_EXT_RISE: div_tick = ext_rise;
			PTM_CK_EXT_FALL: div_tick = ext_fall;
			default: div_tick = 1'b0;
		endcase
	end

	// ======================================================================
	// Counter and comparators
	logic count_en;
	logic match_a;
	logic match_p;
	logic overflow;
	logic pwm_mode;
	logic clr_by_a;
	assign count_en = counter_on && !pause_ctrl && div_tick;
	assign pwm_mode = (op_mode_sel == PTM_MODE_PWM);
	assign match_a = count_en && (count_reg + 10'h001 == cmp_a_value_reg);
	assign match_p = count_en && (count_reg + 10'h001 == cmp_p_value_reg);
	assign overflow = count_en && (count_reg == `PTM_CNT_MAX);
	// clear_sel ignored outside compare and timer modes
	assign clr_by_a = clear_sel && (op_mode_sel == PTM_MODE_CMP || op_mode_sel == PTM_MODE_TMR);

	always_ff @(posedge clk_in or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			count_reg <= `PTM_RST_CNT;
		else if (on_rise)
			count_reg <= `PTM_RST_CNT;
		else if ((clr_by_a && match_a) || (!clr_by_a && match_p))
			count_reg <= `PTM_RST_CNT;
		// pause and off both hold the count
		else if (count_en)
			count_reg <= count_reg + 10'h001;
	end

	always_ff @(posedge clk_in or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			flag_a_reg <= 1'b0;
			flag_p_reg <= 1'b0;
		end
		else
		begin
			// match A raises flag A, match P raises flag P only without A clearing; a set in the clearing write wins.
			flag_a_reg <= match_a ? 1'b1 :
				((wr_lo && avs_address_in == `PTM_OFS_FLAGS && avs_writedata_in[`PTM_FL_A])
				? 1'b0 : flag_a_reg);
			flag_p_reg <= (match_p && !clr_by_a) ? 1'b1 :
				((wr_lo && avs_address_in == `PTM_OFS_FLAGS && avs_writedata_in[`PTM_FL_P])
				? 1'b0 : flag_p_reg);
		end
	end
	assign match_a_flag_out = flag_a_reg;
	assign match_p_flag_out = flag_p_reg;

	// ======================================================================
	// Capture input
	logic cap_rise;
	logic cap_fall;
	logic cap_hit;
	assign cap_rise = capture_src_sel ? ext_rise : (capture_in_pin_in && !cap_in_d_reg);
	assign cap_fall = capture_src_sel ? ext_fall : (!capture_in_pin_in && cap_in_d_reg);
	always_comb
	begin
		case (pin_func_sel)
			PTM_IO_00: cap_hit = cap_rise;
			PTM_IO_01: cap_hit = cap_fall;
			PTM_IO_10: cap_hit = cap_rise || cap_fall;
			default: cap_hit = 1'b0;
		endcase
	end
	always_ff @(posedge clk_in or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			capture_reg <= `PTM_RST_CNT;
			flag_cap_reg <= 1'b0;
		end
		else if (counter_on && op_mode_sel == PTM_MODE_CAP && cap_hit)
		begin
			capture_reg <= count_reg;
			flag_cap_reg <= 1'b1;
		end
		else if (wr_lo && avs_address_in == `PTM_OFS_FLAGS && avs_writedata_in[`PTM_FL_CAP])
			flag_cap_reg <= 1'b0;
	end

	// ======================================================================
	// Output pin
	logic cmp_level_reg;
	logic pwm_level;
	logic pin_level;
	always_ff @(posedge clk_in or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			cmp_level_reg <= 1'b0;
		else if (on_rise)
			cmp_level_reg <= out_level_ctrl;
		// match A drives pin; same level leaves it as is
		else if (op_mode_sel == PTM_MODE_CMP && match_a)
		begin
			case (pin_func_sel)
				PTM_IO_01: cmp_level_reg <= 1'b0;
				PTM_IO_10: cmp_level_reg <= 1'b1;
				PTM_IO_11: cmp_level_reg <= !cmp_level_reg;
				default: cmp_level_reg <= cmp_level_reg;
			endcase
		end
	end

	// Duty stays active below the duty value; a duty at or above the period gives 100 %.
	// PWM pin function
	always_comb
	begin
		case (pin_func_sel)
			PTM_IO_00: pwm_level = 1'b0;
			PTM_IO_01: pwm_level = 1'b1;
			PTM_IO_10: pwm_level = counter_on && (count_reg < cmp_a_value_reg);
			default: pwm_level = counter_on && (count_reg < cmp_a_value_reg);
		endcase
	end

	assign pin_level = pwm_mode ? (pwm_level ? out_level_ctrl : !out_level_ctrl) : cmp_level_reg;
	always_ff @(posedge clk_in or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			timer_out_pin_out <= 1'b0;
			timer_out_pin_oe_out <= 1'b0;
		end
		else
		begin
			timer_out_pin_out <= pin_level ^ out_invert;
			// pin released in timer and capture modes
			timer_out_pin_oe_out <= (op_mode_sel == PTM_MODE_CMP) || pwm_mode;
		end
	end

	// ======================================================================
	// Checks
	// mode decoding drives pin enable
	a_mode_pin_enable: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
		(op_mode_sel == PTM_MODE_TMR) |=> !timer_out_pin_oe_out)
		else $error("Pin driven in timer mode.");
	a_on_rise_clear: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
		on_rise |=> (count_reg == `PTM_RST_CNT))
		else $error("Counter not zeroed on enable.");
	a_pause_holds: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
		(pause_ctrl && !on_rise) |=> $stable(count_reg))
		else $error("Counter moved while paused.");
	a_off_holds: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
		!counter_on |=> $stable(count_reg))
		else $error("Counter moved while off.");
	a_step_one: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
		(count_en && !on_rise && !match_a && !match_p) |=> count_reg == $past(count_reg) + 10'h001)
		else $error("Counter did not step by one.");
	a_p_clear: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
		(!clr_by_a && match_p) |=> count_reg == `PTM_RST_CNT)
		else $error("Period match did not clear.");
	a_no_p_flag: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
		(clr_by_a && !flag_p_reg) |=> !flag_p_reg)
		else $error("P flag set with A clearing.");
	a_init_level: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
		(on_rise && op_mode_sel == PTM_MODE_CMP) |=> cmp_level_reg == $past(out_level_ctrl))
		else $error("Initial level not restored.");
	a_match_flag: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
		match_a |=> flag_a_reg)
		else $error("Match A flag missing.");
	c_match_a: cover property (@(posedge clk_in) disable iff (!rst_n_reg) match_a);
	c_overflow: cover property (@(posedge clk_in) disable iff (!rst_n_reg) overflow);
	c_capture: cover property (@(posedge clk_in) disable iff (!rst_n_reg) flag_cap_reg);
endmodule : ptm_timer

// *** verilog/ptm_map.svh ***
// Register offsets, field positions, reset values and codes of the periodic timer.
// Assumes inclusion by bare name from the design file.
`ifndef PTM_MAP_SVH
`define PTM_MAP_SVH
// ==========================================================================
// Register word addresses (one avs_address_in index per register)
`define PTM_OFS_CTRL0 4'h0
`define PTM_OFS_CTRL1 4'h1
`define PTM_OFS_CNT_LO 4'h2
`define PTM_OFS_CNT_HI 4'h3
`define PTM_OFS_CMPA_LO 4'h4
`define PTM_OFS_CMPA_HI 4'h5
`define PTM_OFS_PER_LO 4'h6
`define PTM_OFS_PER_HI 4'h7
`define PTM_OFS_FLAGS 4'h8
// ==========================================================================
// Control 0 fields
`define PTM_C0_PAUSE 7
`define PTM_C0_CLK_HI 6
`define PTM_C0_CLK_LO 4
`define PTM_C0_ON 3
`define PTM_C0_MASK 8'hF8
// Control 1 fields
`define PTM_C1_MODE_HI 7
`define PTM_C1_MODE_LO 6
`define PTM_C1_IO_HI 5
`define PTM_C1_IO_LO 4
`define PTM_C1_OC 3
`define PTM_C1_POL 2
`define PTM_C1_CAPS 1
`define PTM_C1_CCLR 0
// Flag register fields
`define PTM_FL_A 0
`define PTM_FL_P 1
`define PTM_FL_CAP 2
// ==========================================================================
`define PTM_RST_BYTE 8'h00
`define PTM_RST_CNT 10'h000
`define PTM_CNT_MAX 10'h3FF
`define PTM_HI_MASK 8'h03
`define PTM_DIV4_LAST 6'h03
`define PTM_DIV16_LAST 6'h0F
`define PTM_DIV64_LAST 6'h3F
`define PTM_BAD_READ 32'h0000_0000
`endif

// *** verilog/ptm_pkg.sv ***
// Types of the periodic timer: operating modes, pin functions, clock selects.
// Assumes ptm_map.svh is reachable by the include path.
package ptm_pkg;
	typedef enum logic [1:0] {PTM_MODE_CMP, PTM_MODE_CAP, PTM_MODE_PWM, PTM_MODE_TMR} ptm_mode_t;
	typedef enum logic [2:0]
	{
		PTM_CK_SYS4, PTM_CK_SYS, PTM_CK_H16, PTM_CK_H64,
		PTM_CK_SUB0, PTM_CK_SUB1, PTM_CK_EXT_RISE, PTM_CK_EXT_FALL
	} ptm_clk_t;
	typedef enum logic [1:0] {PTM_IO_00, PTM_IO_01, PTM_IO_10, PTM_IO_11} ptm_io_t;
endpackage : ptm_pkg

// *** verif/ptm_pin_model.sv ***
// Far-side model of the periodic timer pins: external clock and capture input.
// Assumes the pins are sampled on rising edges of clk_in.
`timescale 1ns/10ps
module ptm_pin_model
(
	input wire logic clk_in,
	output logic ext_clk_out,
	output logic cap_out
);
	initial
	begin
		ext_clk_out = 1'b0;
		cap_out = 1'b0;
	end
	// ==========================================================================
	// Pin drivers
	// The idle level is set first, so a falling-edge count starts from a high line.
	task automatic pulse(input int n, input logic idle);
		@(posedge clk_in) ext_clk_out <= idle;
		repeat (n)
		begin
			repeat (3) @(posedge clk_in);
			ext_clk_out <= ~idle;
			repeat (3) @(posedge clk_in);
			ext_clk_out <= idle;
		end
		repeat (6) @(posedge clk_in);
	endtask : pulse
	task automatic cap(input logic v);
		@(posedge clk_in) cap_out <= v;
		repeat (6) @(posedge clk_in);
	endtask : cap
endmodule : ptm_pin_model

// *** verif/testbench.sv ***
// Self-checking bench of the periodic timer over its Avalon register port.
// Assumes ptm_pkg and ptm_pin_model are compiled first.
`timescale 1ns/10ps
module testbench;
	import ptm_pkg::*;
	typedef struct {string name; logic [31:0] exp; logic [31:0] mask;} ptm_note_t;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [3:0] addr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'hF;
	logic [31:0] rdata;
	logic [1:0] resp;
	logic wait_o, pin, oe, fa, fp, ext_clk, cap, pol, e, s;
	logic fsub = 1'b0;
	logic fh = 1'b0;
	logic pin_chk = 1'b0;
	logic [7:0] lfsr = 8'h45;
	logic [7:0] v, n;
	logic [7:0] msk [8] = '{8'hF8, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h03, 8'hFF, 8'h03};
	ptm_note_t notes [$];
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;

	ptm_timer ptm_timer_inst (.clk_in(clk_in), .nrst_in(nrst_in), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
		.avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_o),
		.avs_response_out(resp), .fsub_tick_in(fsub), .fh_tick_in(fh),
		.ext_clk_pin_in(ext_clk), .capture_in_pin_in(cap), .timer_out_pin_out(pin),
		.timer_out_pin_oe_out(oe), .match_a_flag_out(fa), .match_p_flag_out(fp));
	ptm_pin_model ptm_pin_model_inst (.clk_in(clk_in), .ext_clk_out(ext_clk), .cap_out(cap));

	// ==========================================================================
	// Clock, random ticks and timeout
	always #4 clk_in = ~clk_in;
	function automatic logic [7:0] lfsr_next(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : lfsr_next
	always @(posedge clk_in)
	begin
		lfsr <= lfsr_next(lfsr);
		fsub <= lfsr[0];
		fh <= lfsr[1];
		cycles <= cycles + 1;
		if (cycles == 12000)
		begin
			failures++;
			test_done();
		end
	end

	task automatic test_done;
		failures += notes.size();
		$display("Checks %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done

	// ==========================================================================
	// Bus master and result watcher
	// Waitrequest is read at the rising edge, before that edge's updates land, so the
	// request stands until the very edge at which the slave accepts it.
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		wr <= w;
		rd <= ~w;
		wdata <= {24'h0, d};
		do @(posedge clk_in); while (wait_o);
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask : wreg
	task automatic rreg(input logic [3:0] a, input logic [7:0] d, input logic [7:0] m,
		input string nm);
		notes.push_back('{nm, {24'h0, d}, {(a == 4'h8) ? 24'h0 : 24'hFFFFFF, m}});
		bus(1'b0, a, 8'h00);
	endtask : rreg
	task automatic pcheck(input string nm, input logic [3:0] d, input logic [3:0] m);
		notes.push_back('{nm, {28'h0, d}, {28'h0, m}});
		// The pin register trails the level it shows by one cycle, so wait for it.
		repeat (2) @(posedge clk_in);
		pin_chk <= 1'b1;
		@(posedge clk_in);
		pin_chk <= 1'b0;
	endtask : pcheck
	always @(posedge clk_in)
	begin
		logic [31:0] seen;
		ptm_note_t nt;
		if ((rd && !wait_o) || pin_chk)
		begin
			seen = pin_chk ? {28'h0, fp, fa, oe, pin} : rdata;
			n_tests++;
			if (rd && resp !== 2'b00)
			begin
				failures++;
				$display("ERROR response expected 0 seen %h", resp);
			end
			if (notes.size() == 0)
			begin
				failures++;
				$display("ERROR unexpected result expected none seen %h", seen);
			end
			else
			begin
				nt = notes.pop_front();
				if (((seen ^ nt.exp) & nt.mask) !== 32'h0)
				begin
					failures++;
					$display("ERROR %s expected %h seen %h", nt.name, nt.exp, seen);
				end
			end
		end
	end

	// ==========================================================================
	// Scenarios
	initial
	begin
		repeat (20) @(posedge clk_in);
		nrst_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		wreg(4'hB, 8'hFF);
		be <= 4'h0;
		wreg(4'h1, 8'hFF);
		be <= 4'hF;
		for (int i = 0; i < 16; i++)
			rreg(i[3:0], 8'h00, 8'hFF, "reset value");
		for (int i = 1; i < 9; i++)
		begin
			v = lfsr;
			wreg({1'b0, i[2:0]}, v);
			rreg({1'b0, i[2:0]}, v & msk[i[2:0]], 8'hFF, "read back");
		end
		wreg(4'h0, 8'h00);
		wreg(4'h1, {PTM_MODE_TMR, 6'h00});
		wreg(4'h6, 8'h00);
		wreg(4'h7, 8'h00);
		n = {4'h0, lfsr[3:0]} + 8'h03;
		wreg(4'h0, 8'h68);
		ptm_pin_model_inst.pulse(n, 1'b0);
		rreg(4'h2, n, 8'hFF, "count rise");
		rreg(4'h3, 8'h00, 8'hFF, "count high");
		wreg(4'h0, 8'hE8);
		ptm_pin_model_inst.pulse(3, 1'b0);
		rreg(4'h2, n, 8'hFF, "count paused");
		wreg(4'h0, 8'h68);
		ptm_pin_model_inst.pulse(2, 1'b0);
		rreg(4'h2, n + 8'h02, 8'hFF, "count resumed");
		wreg(4'h0, 8'h70);
		ptm_pin_model_inst.pulse(2, 1'b1);
		rreg(4'h2, n + 8'h02, 8'hFF, "count off");
		wreg(4'h0, 8'h78);
		ptm_pin_model_inst.pulse(4, 1'b1);
		rreg(4'h2, 8'h04, 8'hFF, "count fall");
		pcheck("pin released", 4'h0, 4'h2);
		wreg(4'h4, 8'h05);
		wreg(4'h5, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			pol = lfsr[0];
			e = (i[1:0] == 2'b00) ? i[2] : ((i[1:0] == 2'b11) ? ~i[2] : i[1]);
			wreg(4'h0, 8'h60);
			wreg(4'h1, {PTM_MODE_CMP, i[1:0], i[2], pol, 2'b01});
			wreg(4'h8, 8'h07);
			wreg(4'h0, 8'h68);
			pcheck("pin initial", {3'b001, i[2] ^ pol}, 4'hF);
			ptm_pin_model_inst.pulse(5, 1'b0);
			pcheck("pin match", {3'b011, e ^ pol}, 4'hF);
			rreg(4'h2, 8'h00, 8'hFF, "clear on A");
		end
		wreg(4'h0, 8'h60);
		wreg(4'h1, {PTM_MODE_CMP, 6'h00});
		wreg(4'h8, 8'h07);
		wreg(4'h4, 8'h02);
		wreg(4'h6, 8'h03);
		wreg(4'h0, 8'h68);
		ptm_pin_model_inst.pulse(3, 1'b0);
		pcheck("flags A and P", 4'hC, 4'hC);
		rreg(4'h2, 8'h00, 8'hFF, "clear on P");
		for (int i = 0; i < 4; i++)
		begin
			wreg(4'h0, 8'h60);
			wreg(4'h1, {PTM_MODE_PWM, 1'b0, i[0], i[1], 3'b000});
			wreg(4'h0, 8'h68);
			pcheck("pin forced", {3'b001, ~(i[0] ^ i[1])}, 4'h3);
		end
		wreg(4'h0, 8'h60);
		wreg(4'h4, 8'hFF);
		wreg(4'h5, 8'h03);
		wreg(4'h1, {PTM_MODE_PWM, 6'h28});
		wreg(4'h0, 8'h18);
		pcheck("pwm full duty", 4'h3, 4'h3);
		wreg(4'h4, 8'h00);
		wreg(4'h5, 8'h00);
		pcheck("pwm zero duty", 4'h2, 4'h3);
		for (int i = 0; i < 4; i++)
		begin
			s = lfsr[0];
			wreg(4'h0, 8'h10);
			wreg(4'h1, {PTM_MODE_CAP, i[1:0], 2'b00, s, 1'b0});
			wreg(4'h8, 8'h07);
			wreg(4'h0, 8'h18);
			if (s)
				ptm_pin_model_inst.pulse(0, 1'b1);
			else
				ptm_pin_model_inst.cap(1'b1);
			rreg(4'h8, {5'h00, i[0] == 1'b0, 2'b00}, 8'h04, "capture rise");
			wreg(4'h8, 8'h07);
			if (s)
				ptm_pin_model_inst.pulse(0, 1'b0);
			else
				ptm_pin_model_inst.cap(1'b0);
			rreg(4'h8, {5'h00, i[1] != i[0], 2'b00}, 8'h04, "capture fall");
		end
		repeat (4) @(posedge clk_in);
		test_done();
	end
endmodule : testbench
